// >>> erb_top.sv
`timescale 1ns/10ps
// Serial slave answering the error-register read command of both channels
module erb_top #(
    // Arbitrary value, not a real part's code
    parameter logic [7:0] SILICON_REVISION = 8'h5a
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst_n,
    // Serial pins from the host
    input  wire logic                   i_sclk,
    input  wire logic                   i_csn,
    input  wire logic                   i_mosi,
    output logic                        o_miso,
    output logic                        o_miso_oe,
    // Correction step values per channel
    input  wire erb_pkg::erb_steps_t    i_err_corr_ch0,
    input  wire erb_pkg::erb_steps_t    i_err_corr_ch1,
    // Last request and current response
    output logic                        o_frame_done,
    output erb_pkg::erb_frame_t         o_resp_word
);
    logic [2:0]          pins_f;
    logic                sclk_f, csn_f, mosi_f;
    logic                sclk_d_r, csn_d_r;
    logic                sclk_rise, sclk_fall, cs_start, cs_end;

    erb_pkg::erb_frame_t rx_r, rx_nxt;
    erb_pkg::erb_frame_t tx_r, tx_nxt;
    erb_pkg::erb_frame_t resp_r, resp_nxt;
    logic [4:0]          cnt_r, cnt_nxt;
    logic                miso_r, miso_nxt;
    logic                oe_r, oe_nxt;
    logic                done_r, done_nxt;

    logic                is_read, is_invalid;
    logic [7:0]          sel_val;
    erb_pkg::erb_steps_t steps_sel;

    erb_sync3 #(
        .W       (erb_pkg::SYNC_W),
        .RST_VAL (erb_pkg::PIN_IDLE)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_sclk, i_csn, i_mosi}),
        .o_level (pins_f)
    );

    assign sclk_f    = pins_f[2];
    assign csn_f     = pins_f[1];
    assign mosi_f    = pins_f[0];
    assign sclk_rise = sclk_f & ~sclk_d_r & ~csn_f;
    assign sclk_fall = ~sclk_f & sclk_d_r & ~csn_f;
    assign cs_start  = ~csn_f & csn_d_r;
    assign cs_end    = csn_f & ~csn_d_r;

    assign steps_sel = rx_r.channel_select ? i_err_corr_ch1 : i_err_corr_ch0;
    assign is_read   = (rx_r.cmd == erb_pkg::CMD_ERR_READ) && (rx_r.ext == erb_pkg::EXT_ZERO);
    assign is_invalid = (rx_r.cmd == erb_pkg::CMD_ERR_READ) && (rx_r.ext != erb_pkg::EXT_ZERO);

    always_comb begin
        sel_val = erb_pkg::DATA_PAD;
        if (rx_r.reg_select_id <= erb_pkg::REG_ID_STEP_1000) begin
            sel_val = steps_sel[rx_r.reg_select_id];
        end else if (rx_r.reg_select_id == erb_pkg::REG_ID_REVISION) begin
            sel_val = SILICON_REVISION;
        end else begin
            sel_val = erb_pkg::DATA_PAD;
        end
    end

    // Shift and response next-state
    always_comb begin
        rx_nxt   = rx_r;
        tx_nxt   = tx_r;
        resp_nxt = resp_r;
        cnt_nxt  = cnt_r;
        miso_nxt = miso_r;
        // Pin released one clock after the filtered select goes high
        oe_nxt   = ~csn_f;
        done_nxt = 1'b0;
        if (cs_start) begin
            // answer to previous request goes out now
            tx_nxt   = resp_r;
            miso_nxt = resp_r[15];
            cnt_nxt  = '0;
        end else if (sclk_rise) begin
            rx_nxt = {rx_r[14:0], mosi_f};
            // Saturate so an over-long frame cannot wrap back to sixteen
            if (cnt_r != erb_pkg::CNT_SAT) begin
                cnt_nxt = cnt_r + 5'h01;
            end
        end else if (sclk_fall) begin
            tx_nxt   = {tx_r[14:0], 1'b0};
            miso_nxt = tx_r[14];
        end
        if (cs_end) begin
            done_nxt = (cnt_r == erb_pkg::CNT_FULL);
            // Short or long frames leave a harmless zero word
            resp_nxt = erb_pkg::RESP_RESET;
            if (cnt_r == erb_pkg::CNT_FULL) begin
                resp_nxt.channel_select = rx_r.channel_select;
                if (is_read) begin
                    resp_nxt.cmd = erb_pkg::CMD_ERR_READ;
                    resp_nxt.ext = erb_pkg::EXT_ZERO;
                    resp_nxt.reg_select_id = rx_r.reg_select_id;
                    // register byte, low request byte unused
                    resp_nxt.reg_value_byte = sel_val;
                end
                // invalid and other commands answer near zero
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            // Edge detectors start at idle pin levels, so no false edge
            sclk_d_r <= 1'b0;
            csn_d_r  <= 1'b1;
            rx_r     <= erb_pkg::RESP_RESET;
            tx_r     <= erb_pkg::RESP_RESET;
            resp_r   <= erb_pkg::RESP_RESET;
            cnt_r    <= '0;
            miso_r   <= 1'b0;
            oe_r     <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            sclk_d_r <= sclk_f;
            csn_d_r  <= csn_f;
            rx_r     <= rx_nxt;
            tx_r     <= tx_nxt;
            resp_r   <= resp_nxt;
            cnt_r    <= cnt_nxt;
            miso_r   <= miso_nxt;
            oe_r     <= oe_nxt;
            done_r   <= done_nxt;
        end
    end

    assign o_miso       = miso_r;
    assign o_miso_oe    = oe_r;
    assign o_frame_done = done_r;
    assign o_resp_word  = resp_r;

    // Checks
    logic good_end;
    assign good_end = cs_end && (cnt_r == erb_pkg::CNT_FULL);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    chk_cmd_echo: assert property (
        good_end && is_read |=> resp_r.cmd == 2'h3 && resp_r.channel_select == $past(rx_r[15]))
        else $error("Read command echo wrong");
    chk_resp_next: assert property (
        cs_start |=> miso_r == resp_r[15] && tx_r == resp_r)
        else $error("Response not loaded at frame start");
    chk_low_ignored: assert property (
        good_end && is_read && rx_r[10:8] < 3'h5 |=> resp_r.reg_value_byte ==
            $past(rx_r[15] ? i_err_corr_ch1[rx_r[10:8]] : i_err_corr_ch0[rx_r[10:8]]))
        else $error("Data byte not from selected register");
    chk_ext_zero: assert property (
        done_r && resp_r.cmd == 2'h3 |-> resp_r.ext == 2'h0)
        else $error("Extension bits not zero");
    chk_rid_echo: assert property (
        good_end && is_read |=> resp_r.reg_select_id == $past(rx_r[10:8]))
        else $error("Identifier echo wrong");
    chk_step_map: assert property (
        good_end && is_read && rx_r[10:8] == 3'h2 && !rx_r[15]
        |=> resp_r.reg_value_byte == $past(i_err_corr_ch0[2]))
        else $error("600 mV step not returned");
    chk_rev_code: assert property (
        good_end && is_read && rx_r[10:8] == 3'h5 |=> resp_r.reg_value_byte == SILICON_REVISION)
        else $error("Revision code not returned");
    chk_pad_zero: assert property (
        good_end && is_read && rx_r[10:9] == 2'h3 |=> resp_r.reg_value_byte == 8'h00)
        else $error("Pad identifier data not zero");
    chk_never_ones: assert property (
        good_end && is_invalid |=> resp_r != erb_pkg::WORD_ONES ##1 resp_r != erb_pkg::WORD_ONES)
        else $error("Invalid command answered all ones");
    chk_miso_shift: assert property (
        sclk_fall && !cs_start |=> miso_r == $past(tx_r[14]))
        else $error("Serial output not shifted");

    // Per-channel map, quiet answers and framing
    chk_ch0_first: assert property (
        good_end && is_read && rx_r[10:8] == 3'h0 && !rx_r[15]
        |=> resp_r.reg_value_byte == $past(i_err_corr_ch0[0]))
        else $error("200 mV step of channel 0 not returned");
    chk_ch1_last: assert property (
        good_end && is_read && rx_r[10:8] == 3'h4 && rx_r[15]
        |=> resp_r.reg_value_byte == $past(i_err_corr_ch1[4]))
        else $error("1000 mV step of channel 1 not returned");
    chk_invalid_quiet: assert property (
        good_end && is_invalid |=> resp_r[14:0] == 15'h0000)
        else $error("Invalid command answer not quiet");
    chk_short_drop: assert property (
        cs_end && cnt_r != 5'h10 |=> resp_r == 16'h0000)
        else $error("Bad length frame left an answer");
    chk_resp_hold: assert property (
        !cs_end |=> resp_r == $past(resp_r))
        else $error("Answer changed between frame ends");
    chk_done_pulse: assert property (
        done_r |=> !done_r)
        else $error("Frame done wider than one cycle");
    chk_oe_frame: assert property (
        cs_start |=> oe_r)
        else $error("Data pin not driven in frame");
    chk_oe_idle: assert property (
        csn_f && $past(csn_f) |-> !oe_r)
        else $error("Data pin driven while deselected");

    cov_read_frame: cover property (good_end && is_read);
    cov_invalid:    cover property (good_end && is_invalid);
    cov_rev_read:   cover property (good_end && is_read && rx_r[10:8] == 3'h5);
    cov_short:      cover property (cs_end && cnt_r != 5'h10);
    cov_ch1_read:   cover property (good_end && is_read && rx_r[15]);
endmodule // erb_top

// >>> erb_pkg.sv
// What this block does
// - Top bit picks channel; bits 14:11 of 1100 mean error-register read.
// - Identifier in bits 10:8; its contents come back in the next frame.
// - Low byte of the request is ignored for the read command.
// - Response drives bits 12:11 as zero.
// - Response echoes in bits 10:8 the identifier being returned.
// - Selected register's eight bits sit in the response low byte.
// - Ids 0..4 pick 200..1000 mV correction steps; id 5 picks revision.
// - Bits 14:11 of 1101, 1110, 1111 are invalid commands.
// - Response to an invalid command is never all ones.
package erb_pkg;

    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned NUM_CHAN    = 2;
    localparam int unsigned NUM_STEPS   = 5;

    // Command field values, bits 14:13 and 12:11
    localparam logic [1:0]  CMD_ERR_READ = 2'h3;
    localparam logic [1:0]  EXT_ZERO     = 2'h0;

    // Register identifiers
    localparam logic [2:0]  REG_ID_STEP_1000 = 3'h4;
    localparam logic [2:0]  REG_ID_REVISION  = 3'h5;

    // Idle and reset words; an all-ones word must never leave the block
    localparam logic [15:0] RESP_RESET   = 16'h0000;
    localparam logic [15:0] WORD_ONES    = 16'hffff;
    localparam logic [7:0]  DATA_PAD     = 8'h00;
    localparam logic [4:0]  CNT_FULL     = 5'h10;
    localparam logic [4:0]  CNT_SAT      = 5'h1f;

    // Pin sampler width, pin idle levels {sclk, csn, mosi}
    localparam int unsigned SYNC_W       = 3;
    localparam logic [2:0]  PIN_IDLE     = 3'h2;

    typedef struct packed {
        logic       channel_select;
        logic [1:0] cmd;
        logic [1:0] ext;
        logic [2:0] reg_select_id;
        logic [7:0] reg_value_byte;
    } erb_frame_t;

    // Five correction steps of one channel, index 0 is 200 mV
    typedef logic [NUM_STEPS-1:0][7:0] erb_steps_t;

endpackage

// >>> erb_sync3.sv
`timescale 1ns/10ps
// Three-stage pin sampler; level only moves once stages two and three agree
module erb_sync3 #(
    parameter int unsigned W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Pins and filtered level
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [W-1:0] lvl_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                lvl_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_r  <= RST_VAL;
            s2_r  <= RST_VAL;
            s3_r  <= RST_VAL;
            lvl_r <= RST_VAL;
        end else begin
            s1_r  <= i_async;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule // erb_sync3

// >>> erb_host.sv
`timescale 1ns/10ps
// Host controller model, serial mode 0, link clock 125 ns
module erb_host (
    // Pins toward the device
    output logic      o_sclk,
    output logic      o_csn,
    output logic      o_mosi,
    input  wire logic i_miso,
    input  wire logic i_miso_oe
);
    initial begin
        o_sclk = 1'b0;
        o_csn  = 1'b1;
        o_mosi = 1'b0;
    end
    // Link clock only toggles inside a frame; undriven data reads as z
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        o_csn = 1'b0;
        for (int b = 15; b > 15 - n; b--) begin
            o_mosi = tx[b];
            #62.5 o_sclk = 1'b1;
            rx = {rx[14:0], i_miso_oe ? i_miso : 1'bz};
            #62.5 o_sclk = 1'b0;
        end
        #62.5 o_csn = 1'b1;
        // Released line must not keep the last bit
        o_mosi = ~o_mosi;
    endtask
endmodule // erb_host

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] REV = 8'h3c;
    logic                i_clk = 1'b0;
    logic                i_rst_n = 1'b0;
    logic                sclk, csn, mosi, miso, miso_oe, frame_done;
    erb_pkg::erb_frame_t resp_word;
    erb_pkg::erb_steps_t corr [2] = '{40'h8877665544, 40'h0123456789};
    logic [15:0]         rx;
    logic [15:0]         pending = 16'h0000;
    int                  mismatches = 0;
    int                  checks_done = 0;

    initial begin
        forever #4 i_clk = ~i_clk;
    end

    erb_top #(.SILICON_REVISION(REV)) i_erb_top (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_csn(csn), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(miso_oe), .i_err_corr_ch0(corr[0]),
        .i_err_corr_ch1(corr[1]), .o_frame_done(frame_done), .o_resp_word(resp_word));
    erb_host i_erb_host (.o_sclk(sclk), .o_csn(csn), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe(miso_oe));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One frame; rx must carry the answer promised by the frame before
    task automatic frame(input logic [15:0] tx, input int n, input logic [15:0] exp);
        int k;
        i_erb_host.xfer(tx, n, rx);
        // A cut frame only carries the leading bits of the answer
        check(rx, pending >> (16 - n));
        pending = 16'h0000;
        if (n == 16) begin
            for (k = 0; k < 40 && frame_done !== 1'b1; k++) begin
                @(posedge i_clk);
                #1;
            end
            if (k == 40) begin
                mismatches++;
                $display("mismatch at %0t: no frame done", $time);
                summarize();
            end
            check(resp_word, exp);
            pending = exp;
        end
        #1000;
    endtask

    function automatic logic [15:0] rd_exp(input logic chan, input logic [2:0] id);
        logic [7:0] v;
        v = 8'h00;
        if (id < 3'h5) begin
            v = corr[chan][id];
        end else if (id == 3'h5) begin
            v = REV;
        end
        return {chan, 2'h3, 2'h0, id, v};
    endfunction

    // Every channel and identifier, low request byte all zeros or all ones
    task automatic t_reads();
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 8; i++) begin
                frame({c[0], 2'h3, 2'h0, i[2:0], {8{i[0]}}}, 16, rd_exp(c[0], i[2:0]));
            end
        end
        $display("test reads done");
    endtask

    // Invalid codes then a read; none may answer all ones
    task automatic t_invalid();
        for (int c = 13; c < 16; c++) begin
            frame({1'b1, c[3:0], 11'h7ff}, 16, 16'h8000);
            check({15'h0000, rx === 16'hffff}, 16'h0000);
        end
        frame({1'b0, 2'h3, 2'h0, 3'h4, 8'h5a}, 16, rd_exp(1'b0, 3'h4));
        check({15'h0000, rx === 16'hffff}, 16'h0000);
        $display("test invalid done");
    endtask

    // Short frame is dropped, its successor answers zero
    task automatic t_short();
        frame({1'b0, 2'h3, 2'h0, 3'h2, 8'h00}, 12, 16'h0000);
        frame({1'b1, 2'h3, 2'h0, 3'h3, 8'h00}, 16, rd_exp(1'b1, 3'h3));
        frame({1'b1, 2'h3, 2'h0, 3'h5, 8'h00}, 16, rd_exp(1'b1, 3'h5));
        $display("test short done");
    endtask

    initial begin
        repeat (8) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        repeat (8) @(posedge i_clk);
        t_reads();
        t_invalid();
        t_short();
        summarize();
    end
endmodule // testbench
